// ### sdl_cfg.svh
`ifndef SDL_CFG_SVH
`define SDL_CFG_SVH

// ----------------------------------------------------------------------------
// Word and buffer geometry
// ----------------------------------------------------------------------------
`define SDL_WORD_BITS 12
`define SDL_BUF_DEPTH 2

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define SDL_CODE_RESET 12'h000
`define SDL_SHIFT_RESET 12'h000
`define SDL_STROBE_IDLE 1'h1
`define SDL_PIN_LOW 1'h0

`endif

// ### sdl_pkg.sv
`include "sdl_cfg.svh"

package sdl_pkg;

    // ------------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------------
    typedef logic [`SDL_WORD_BITS-1:0] sdl_word_t;

endpackage

// ### sdl_load_interface.sv
`timescale 1ns/100ps
`include "sdl_cfg.svh"

// Overview of operation
// - Serial data is sampled into the shift register on each serial clock rise while the strobe is low.
// - Words arrive most significant bit first and shift upward so the first bit ends at the top.
// - A rising strobe copies the whole shift register into the converter holding register.
// - While the strobe is high the serial clock is gated off, so nothing shifts and the output holds.
// - The shift register is twelve bits long and its shifted-out end drives the serial output pin.
// - Devices cascade by chaining serial output to serial input while sharing clock and strobe.
// - Any code from zero to full scale is accepted and drives the output in proportion, zero at bottom.
// - The serial output changes after each serial clock rise with the newly shifted-out bit.
module sdl_load_interface #(
    parameter int unsigned WORD_BITS = `SDL_WORD_BITS,
    parameter int unsigned BUF_DEPTH = `SDL_BUF_DEPTH
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_reset,
    // Serial port pins
    input wire logic i_serial_clock,
    input wire logic i_serial_data,
    input wire logic i_select_load_strobe,
    output logic o_serial_data,
    // Converter holding register
    output logic [WORD_BITS-1:0] o_dac_code,
    // Loaded word stream
    output logic o_word_valid,
    output logic [WORD_BITS-1:0] o_word_data,
    input wire logic i_word_ready,
    output logic o_buffer_ready
);

    localparam int unsigned PTR_BITS = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
    localparam int unsigned CNT_BITS = $clog2(BUF_DEPTH + 1);
    localparam logic [CNT_BITS-1:0] CNT_FULL = CNT_BITS'(BUF_DEPTH);
    localparam logic [CNT_BITS-1:0] CNT_ONE = CNT_BITS'(1);

    function automatic logic [PTR_BITS-1:0] ptr_inc(input logic [PTR_BITS-1:0] ptr);
        logic [PTR_BITS-1:0] result;
        result = (ptr == PTR_BITS'(BUF_DEPTH - 1)) ? '0 : ptr + PTR_BITS'(1);
        return result;
    endfunction

    // ------------------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ------------------------------------------------------------------------
    logic sclk_meta, sclk_sync, data_meta, data_sync, strobe_meta, strobe_sync;
    logic gated_prev, strobe_prev;
    logic next_sclk_meta, next_sclk_sync, next_data_meta, next_data_sync;
    logic next_strobe_meta, next_strobe_sync, next_gated_prev, next_strobe_prev;
    logic gated_clock, shift_pulse, load_pulse;

    always_comb begin
        next_sclk_meta = i_serial_clock;
        next_sclk_sync = sclk_meta;
        next_data_meta = i_serial_data;
        next_data_sync = data_meta;
        next_strobe_meta = i_select_load_strobe;
        next_strobe_sync = strobe_meta;
        // Same AND gate as the pin logic, so a high clock at strobe fall
        // still yields the extra shift the sender must avoid
        gated_clock = sclk_sync & ~strobe_sync;
        shift_pulse = gated_clock & ~gated_prev;
        load_pulse = strobe_sync & ~strobe_prev;
        next_gated_prev = gated_clock;
        next_strobe_prev = strobe_sync;
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            sclk_meta <= `SDL_PIN_LOW;
            sclk_sync <= `SDL_PIN_LOW;
            data_meta <= `SDL_PIN_LOW;
            data_sync <= `SDL_PIN_LOW;
            // Strobe idles high so release from reset loads nothing
            strobe_meta <= `SDL_STROBE_IDLE;
            strobe_sync <= `SDL_STROBE_IDLE;
            strobe_prev <= `SDL_STROBE_IDLE;
            gated_prev <= `SDL_PIN_LOW;
        end else begin
            sclk_meta <= next_sclk_meta;
            sclk_sync <= next_sclk_sync;
            data_meta <= next_data_meta;
            data_sync <= next_data_sync;
            strobe_meta <= next_strobe_meta;
            strobe_sync <= next_strobe_sync;
            strobe_prev <= next_strobe_prev;
            gated_prev <= next_gated_prev;
        end
    end

    // ------------------------------------------------------------------------
    // Shift register, serial output and holding register
    // ------------------------------------------------------------------------
    logic [WORD_BITS-1:0] shift_reg, next_shift_reg, next_dac_code;
    logic next_serial_data;

    always_comb begin
        next_shift_reg = shift_reg;
        if (shift_pulse) begin
            next_shift_reg = {shift_reg[WORD_BITS-2:0], data_sync};
        end
        // Top stage leaves one cycle after the shift
        next_serial_data = shift_reg[WORD_BITS-1];
        // Code passes unaltered: full range, zero maps to bottom
        next_dac_code = load_pulse ? shift_reg : o_dac_code;
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            shift_reg <= WORD_BITS'(`SDL_SHIFT_RESET);
            o_serial_data <= `SDL_PIN_LOW;
            o_dac_code <= WORD_BITS'(`SDL_CODE_RESET);
        end else begin
            shift_reg <= next_shift_reg;
            o_serial_data <= next_serial_data;
            o_dac_code <= next_dac_code;
        end
    end

    // ------------------------------------------------------------------------
    // Loaded word buffer
    // ------------------------------------------------------------------------
    // A load into a full buffer is dropped; the serial link cannot be
    // stalled, so o_buffer_ready warns the sender to pace its strobes.
    logic [WORD_BITS-1:0] buf_mem [BUF_DEPTH];
    logic [WORD_BITS-1:0] next_buf_mem [BUF_DEPTH];
    logic [PTR_BITS-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [CNT_BITS-1:0] buf_count, next_buf_count;
    logic next_word_valid, next_buffer_ready, push, pop;
    logic [WORD_BITS-1:0] next_word_data;

    always_comb begin
        push = load_pulse && (buf_count != CNT_FULL);
        pop = o_word_valid && i_word_ready;
        next_buf_mem = buf_mem;
        if (push) begin
            next_buf_mem[wr_ptr] = shift_reg;
        end
        next_wr_ptr = push ? ptr_inc(wr_ptr) : wr_ptr;
        next_rd_ptr = pop ? ptr_inc(rd_ptr) : rd_ptr;
        next_buf_count = buf_count;
        if (push && !pop) begin
            next_buf_count = buf_count + CNT_ONE;
        end else if (pop && !push) begin
            next_buf_count = buf_count - CNT_ONE;
        end
        next_word_valid = (next_buf_count != '0);
        next_word_data = next_buf_mem[next_rd_ptr];
        next_buffer_ready = (next_buf_count != CNT_FULL);
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            for (int i = 0; i < BUF_DEPTH; i++) begin
                buf_mem[i] <= '0;
            end
            wr_ptr <= '0;
            rd_ptr <= '0;
            buf_count <= '0;
            o_word_valid <= 1'h0;
            o_word_data <= '0;
            o_buffer_ready <= 1'h1;
        end else begin
            buf_mem <= next_buf_mem;
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            buf_count <= next_buf_count;
            o_word_valid <= next_word_valid;
            o_word_data <= next_word_data;
            o_buffer_ready <= next_buffer_ready;
        end
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    sequence shift_seen_s;
        shift_pulse;
    endsequence

    sequence load_seen_s;
        load_pulse ##1 (o_dac_code == $past(shift_reg));
    endsequence

    shift_data_a: assert property (@(posedge i_clock) disable iff (i_reset)
        shift_seen_s |=> (shift_reg[0] == $past(data_sync)))
        else $error("shift register missed the sampled data bit");

    msb_first_a: assert property (@(posedge i_clock) disable iff (i_reset)
        shift_seen_s |=> (shift_reg[WORD_BITS-1:1] == $past(shift_reg[WORD_BITS-2:0])))
        else $error("shift did not move bits toward the top");

    load_copy_a: assert property (@(posedge i_clock) disable iff (i_reset)
        load_pulse |-> load_seen_s)
        else $error("holding register did not take the shift register");

    gate_hold_a: assert property (@(posedge i_clock) disable iff (i_reset)
        strobe_sync |=> ($stable(shift_reg) ##1 $stable(o_serial_data)))
        else $error("shift or serial output moved while strobe high");

    dout_stage_a: assert property (@(posedge i_clock) disable iff (i_reset)
        shift_seen_s |-> ##2 (o_serial_data == $past(shift_reg[WORD_BITS-2], 2)))
        else $error("serial output is not the shifted-out top stage");

    dout_change_a: assert property (@(posedge i_clock) disable iff (i_reset)
        !$stable(o_serial_data) |-> $past(shift_pulse, 2))
        else $error("serial output changed without a clock rise");

    code_stable_a: assert property (@(posedge i_clock) disable iff (i_reset)
        !$stable(o_dac_code) |-> $past(load_pulse))
        else $error("converter code changed without a load");

    buffer_keep_a: assert property (@(posedge i_clock) disable iff (i_reset)
        (o_word_valid && !i_word_ready) |=> (o_word_valid && $stable(o_word_data)))
        else $error("buffer head lost while stalled");

    buffer_fill_a: assert property (@(posedge i_clock) disable iff (i_reset)
        (load_pulse && o_buffer_ready) |=> o_word_valid)
        else $error("accepted load did not appear in the buffer");

endmodule

// ### sdl_host.sv
`timescale 1ns/100ps
// ----
// Host controller model
// ----
module sdl_host (
    input wire logic i_clock,
    input wire logic i_chain_data,
    output logic o_serial_clock,
    output logic o_serial_data,
    output logic o_select_load_strobe
);
    int hp = 8;
    logic [11:0] got = 12'h000;
    initial begin
        o_serial_clock = 1'h0;
        o_serial_data = 1'h1;
        o_select_load_strobe = 1'h1;
    end
    task automatic wt(input int n);
        repeat (n) @(negedge i_clock);
    endtask
    task automatic open_frame();
        o_serial_clock = 1'h0;
        wt(hp);
        o_select_load_strobe = 1'h0;
        wt(hp);
    endtask
    // Sampled just before each rise, as a downstream device would
    task automatic send(input logic [11:0] w);
        for (int i = 11; i >= 0; i--) begin
            o_serial_data = w[i];
            wt(hp);
            got = {got[10:0], i_chain_data};
            o_serial_clock = 1'h1;
            wt(hp);
            o_serial_clock = 1'h0;
        end
    endtask
    // Released data line toggles so a stale level cannot pass
    task automatic load();
        wt(hp);
        o_select_load_strobe = 1'h1;
        o_serial_data = ~o_serial_data;
        wt(hp);
    endtask
    task automatic idle_clk();
        repeat (3) begin
            o_serial_clock = 1'h1;
            o_serial_data = ~o_serial_data;
            wt(hp);
            o_serial_clock = 1'h0;
            wt(hp);
        end
    endtask
endmodule

// ### testbench.sv
`timescale 1ns/100ps
// ----
// Self-checking bench
// ----
module testbench;
    logic i_clock = 1'h0;
    logic i_reset = 1'h1;
    logic rdy = 1'h0;
    logic sclk, sdi, stb, sdo, vld, brdy;
    sdl_pkg::sdl_word_t code, wd;
    int n_errors = 0;
    int tests_run = 0;
    always #5 i_clock = ~i_clock;
    sdl_load_interface i_dut (.i_clock(i_clock), .i_reset(i_reset), .i_serial_clock(sclk),
        .i_serial_data(sdi), .i_select_load_strobe(stb), .o_serial_data(sdo), .o_dac_code(code),
        .o_word_valid(vld), .o_word_data(wd), .i_word_ready(rdy), .o_buffer_ready(brdy));
    sdl_host i_host (.i_clock(i_clock), .i_chain_data(sdo), .o_serial_clock(sclk),
        .o_serial_data(sdi), .o_select_load_strobe(stb));
    task automatic chk(input logic [11:0] g, input logic [11:0] e);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic word(input logic [11:0] w);
        i_host.open_frame();
        i_host.send(w);
        i_host.load();
    endtask
    task automatic pop(input logic [11:0] w);
        chk({11'h000, vld}, 12'h001);
        chk(wd, w);
        rdy = 1'h1;
        @(negedge i_clock);
        rdy = 1'h0;
    endtask
    task automatic t_reset();
        chk(code, 12'h000);
        chk({vld, brdy, sdo}, 12'h002);
        $display("reset done");
    endtask
    task automatic t_single();
        word(12'ha5c);
        chk(code, 12'ha5c);
        pop(12'ha5c);
        $display("single done");
    endtask
    task automatic t_scale();
        logic [11:0] v[2] = '{12'h000, 12'hfff};
        foreach (v[i]) begin
            word(v[i]);
            chk(code, v[i]);
            pop(v[i]);
        end
        $display("scale done");
    endtask
    task automatic t_cascade();
        i_host.open_frame();
        i_host.send(12'h6b1);
        chk(i_host.got, 12'hfff);
        i_host.send(12'h9e4);
        chk(i_host.got, 12'h6b1);
        i_host.load();
        chk(code, 12'h9e4);
        pop(12'h9e4);
        $display("cascade done");
    endtask
    task automatic t_gate();
        i_host.hp = 16;
        word(12'hc93);
        i_host.idle_clk();
        chk(code, 12'hc93);
        chk({11'h000, sdo}, 12'h001);
        i_host.open_frame();
        i_host.send(12'h0f0);
        chk(i_host.got, 12'hc93);
        i_host.load();
        i_host.hp = 8;
        pop(12'hc93);
        pop(12'h0f0);
        $display("gate done");
    endtask
    task automatic t_buffer();
        word(12'h111);
        word(12'h222);
        chk({11'h000, brdy}, 12'h000);
        word(12'h333);
        chk(code, 12'h333);
        pop(12'h111);
        pop(12'h222);
        chk({vld, brdy}, 12'h001);
        $display("buffer done");
    endtask
    task automatic tally_and_finish();
        $display("errors=%0d checks=%0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(negedge i_clock);
        i_reset = 1'h0;
        repeat (4) @(negedge i_clock);
        t_reset();
        t_single();
        t_scale();
        t_cascade();
        t_gate();
        t_buffer();
        tally_and_finish();
    end
    // Roughly seven times the expected run
    initial begin
        #200000;
        n_errors++;
        tally_and_finish();
    end
endmodule
